// file: rtl/pfm_pad_ctrl.sv
// Functional notes
// - pins float in and right after reset except memory, control and crystal out
// - memory control and address outputs drive high in and right after reset
// - synchronous memory clock keeps toggling at system rate during reset
// - hibernate floats all outputs unless a pin says otherwise
// - input buffers of bidirectional pins stay disabled in and right after reset and in hibernate
// - reconfigurable pins start in default function, port f default is gpio
// - byte enables for async accesses, data masks for sync accesses
// - port f pins 0 to 7 offer parallel port data bit of same index
// - pins 0 to 6 offer mii tx2, rx2, tx3, rx3, rx clock, valid, collision
// - pins 1 to 6 offer pwm ah..cl, pin 7 pwm sync
// - pins 0,1,3,4 timer 6,7,0,1 clocks; pins 5,6 timer 0,1 captures
// - pin 0 offers spi b select 2, pin 7 spi a select 1
`timescale 1ns/1ns
`default_nettype none
`include "pfm_map.svh"

module pfm_pad_ctrl (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // power state
  input wire logic hibernate_req,
  // external memory controller side
  input wire pfm_pkg::pfm_emi_s emi_in,
  input wire logic [15:0] data_out_in,
  input wire logic data_oe_in,
  input wire logic [1:0] async_byte_enable,
  input wire logic [1:0] sync_data_mask,
  input wire logic mem_access_sync,
  input wire logic xtal_in,
  // external memory pads
  output pfm_pkg::pfm_emi_s emi_out,
  output logic emi_oe,
  output logic [15:0] data_out,
  output logic data_oe,
  output logic data_ie,
  output logic [1:0] byte_enable_or_mask,
  output logic sync_mem_clock_out,
  output logic buffered_crystal_out,
  output logic buffered_crystal_oe,
  // port f configuration, one 3-bit function code per pin
  input wire logic [23:0] pf_fn_sel,
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe,
  input wire logic [7:0] gpio_ie,
  // peripheral outputs to port f
  input wire logic mii_tx_bit2,
  input wire logic mii_tx_bit3,
  input wire logic [7:0] parallel_port_out,
  input wire logic parallel_port_oe,
  input wire logic [5:0] pwm_out,
  input wire logic pwm_sync_out,
  input wire logic spi_b_select2,
  input wire logic spi_a_select1,
  // port f pads
  input wire logic [7:0] portf_pin_in,
  output logic [7:0] portf_pin_out,
  output logic [7:0] portf_pin_oe,
  output logic [7:0] portf_pin_ie,
  // peripheral inputs from port f
  output logic [7:0] gpio_in,
  output logic [7:0] parallel_port_in,
  output pfm_pkg::pfm_mii_rx_s mii_rx,
  output pfm_pkg::pfm_tmr_s timer_in
);
  import pfm_pkg::*;

  localparam logic [47:0] AVAIL_MAP = `PFM_AVAIL_MAP;
  localparam logic [7:0] MII_OUT = `PFM_MII_OUT_MASK;
  localparam logic [3:0] POST_CYCLES = 4'(`PFM_POST_RESET_CYCLES);

  pfm_state_s st;
  pfm_state_s next_st;

  // -----------------------------------------------------------
  // pad mode and external memory interface
  // -----------------------------------------------------------
  always_comb
  begin
    next_st = st;
    // system clock is mclk divided by two
    if (st.sync_mem_clock_out)
    begin
      next_st.sync_mem_clock_out = 1'b0;
    end
    else
    begin
      next_st.sync_mem_clock_out = 1'b1;
    end
    next_st.buffered_crystal_out = xtal_in;
    if (reset)
    begin
      next_st.mode = PFM_MODE_RESET;
      next_st.cnt = 4'h0;
    end
    else
    begin
      case (st.mode)
        PFM_MODE_RESET:
        begin
          next_st.mode = PFM_MODE_POST;
          next_st.cnt = 4'h0;
        end
        PFM_MODE_POST:
        begin
          next_st.cnt = st.cnt + 4'h1;
          if (st.cnt + 4'h1 >= POST_CYCLES)
          begin
            next_st.mode = PFM_MODE_RUN;
          end
        end
        PFM_MODE_RUN:
        begin
          if (hibernate_req)
          begin
            next_st.mode = PFM_MODE_HIBER;
          end
        end
        PFM_MODE_HIBER:
        begin
          if (!hibernate_req)
          begin
            next_st.mode = PFM_MODE_RUN;
          end
        end
        default:
        begin
          next_st.mode = PFM_MODE_RESET;
        end
      endcase
    end
    case (next_st.mode)
      PFM_MODE_RUN:
      begin
        next_st.emi = emi_in;
        next_st.emi_oe = 1'b1;
        next_st.data_out = data_out_in;
        next_st.data_oe = data_oe_in;
        next_st.data_ie = !data_oe_in;
        next_st.byte_enable_or_mask = mem_access_sync ?
          sync_data_mask : async_byte_enable;
        next_st.xtal_oe = 1'b1;
        next_st.force_hiz = 1'b0;
      end
      PFM_MODE_HIBER:
      begin
        next_st.emi_oe = 1'b0;
        next_st.data_oe = 1'b0;
        next_st.data_ie = 1'b0;
        next_st.xtal_oe = 1'b0;
        next_st.force_hiz = 1'b1;
      end
      default:
      begin
        // reset and the hold time after it
        next_st.emi = '1;
        next_st.emi.addr = `PFM_EMI_ADDR_RESET;
        next_st.emi_oe = 1'b1;
        next_st.byte_enable_or_mask = `PFM_BE_RESET;
        next_st.data_out = 16'h0000;
        next_st.data_oe = 1'b0;
        next_st.data_ie = 1'b0;
        next_st.xtal_oe = 1'b1;
        next_st.force_hiz = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    st <= next_st;
  end

  assign emi_out = st.emi;
  assign emi_oe = st.emi_oe;
  assign data_out = st.data_out;
  assign data_oe = st.data_oe;
  assign data_ie = st.data_ie;
  assign byte_enable_or_mask = st.byte_enable_or_mask;
  assign sync_mem_clock_out = st.sync_mem_clock_out;
  assign buffered_crystal_out = st.buffered_crystal_out;
  assign buffered_crystal_oe = st.xtal_oe;

  // -----------------------------------------------------------
  // port f function routing
  // -----------------------------------------------------------
  logic [7:0] mii_pin_out;
  logic [7:0] pwm_pin_out;
  logic [7:0] spi_pin_out;
  logic [5:0] pin_in [8];

  assign mii_pin_out = {5'h00, mii_tx_bit3, 1'b0, mii_tx_bit2};
  assign pwm_pin_out = {pwm_sync_out, pwm_out, 1'b0};
  assign spi_pin_out = {spi_a_select1, 6'h00, spi_b_select2};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pin
      logic [5:0] out_v;
      logic [5:0] oe_v;
      logic [5:0] ie_v;
      assign out_v = {1'b0, spi_pin_out[gi], pwm_pin_out[gi],
                      parallel_port_out[gi], mii_pin_out[gi], gpio_out[gi]};
      assign oe_v = {1'b0, 1'b1, 1'b1, parallel_port_oe, MII_OUT[gi], gpio_oe[gi]};
      assign ie_v = {1'b1, 1'b0, 1'b0, !parallel_port_oe, !MII_OUT[gi],
                     gpio_ie[gi]};
      pfm_pin_sel #(
        .AVAIL(AVAIL_MAP[gi*6 +: 6])
      ) u_sel (
        .mclk(mclk),
        .reset(reset),
        .force_hiz(st.force_hiz),
        .fn_sel(pf_fn_sel[gi*3 +: 3]),
        .out_vec(out_v),
        .oe_vec(oe_v),
        .ie_vec(ie_v),
        .pad_in(portf_pin_in[gi]),
        .pad_out(portf_pin_out[gi]),
        .pad_oe(portf_pin_oe[gi]),
        .pad_ie(portf_pin_ie[gi]),
        .in_vec(pin_in[gi])
      );
      assign gpio_in[gi] = pin_in[gi][0];
      assign parallel_port_in[gi] = pin_in[gi][2];
    end
  endgenerate

  // -----------------------------------------------------------
  // inputs to peripherals
  // -----------------------------------------------------------
  assign mii_rx.mii_rx_bit2 = pin_in[1][1];
  assign mii_rx.mii_rx_bit3 = pin_in[3][1];
  assign mii_rx.mii_rx_clock = pin_in[4][1];
  assign mii_rx.mii_rx_valid = pin_in[5][1];
  assign mii_rx.mii_collision = pin_in[6][1];
  assign timer_in.timer6_alt_clock = pin_in[0][5];
  assign timer_in.timer7_alt_clock = pin_in[1][5];
  assign timer_in.timer0_alt_clock = pin_in[3][5];
  assign timer_in.timer1_alt_clock = pin_in[4][5];
  assign timer_in.timer0_alt_capture = pin_in[5][5];
  assign timer_in.timer1_alt_capture = pin_in[6][5];

endmodule
`default_nettype wire

// file: shared/pfm_map.svh
`ifndef PFM_MAP_SVH
`define PFM_MAP_SVH

// number of selectable functions per port f pin
`define PFM_FN_COUNT 6
`define PFM_PIN_COUNT 8

// function availability, six bits per pin, pin 7 in the top bits
// bit order: gpio, mii, parallel port, pwm, spi select, timer input
`define PFM_AVAIL_MAP 48'h76fb_efbc_fbf7

// pins whose mii function is an output (transmit bits)
`define PFM_MII_OUT_MASK 8'h05

// reset values of the external memory outputs
`define PFM_EMI_ADDR_RESET 19'h7_ffff
`define PFM_BE_RESET 2'h3

// clock and the hold time after reset release
`define PFM_MCLK_PERIOD_NS 8
`define PFM_POST_RESET_NS 40
`define PFM_POST_RESET_CYCLES \
  ((`PFM_POST_RESET_NS + `PFM_MCLK_PERIOD_NS - 1) / `PFM_MCLK_PERIOD_NS)

`endif

// file: shared/pfm_pkg.sv
package pfm_pkg;

  // -----------------------------------------------------------
  // pin functions
  // -----------------------------------------------------------
  typedef enum logic [2:0] {
    PFM_FN_GPIO,
    PFM_FN_MII,
    PFM_FN_PPI,
    PFM_FN_PWM,
    PFM_FN_SPI,
    PFM_FN_TMR
  } pfm_fn_e;

  typedef enum logic [1:0] {
    PFM_MODE_RESET,
    PFM_MODE_POST,
    PFM_MODE_RUN,
    PFM_MODE_HIBER
  } pfm_mode_e;

  // -----------------------------------------------------------
  // carriers
  // -----------------------------------------------------------
  typedef struct packed {
    logic [19:1] addr;
    logic [1:0] async_bank_select_n;
    logic async_read_en_n;
    logic async_write_en_n;
    logic sdram_row_strobe_n;
    logic sdram_col_strobe_n;
    logic sdram_write_en_n;
    logic sdram_clock_en;
    logic sdram_addr10;
    logic sdram_bank_select_n;
  } pfm_emi_s;

  typedef struct packed {
    logic mii_rx_bit2;
    logic mii_rx_bit3;
    logic mii_rx_clock;
    logic mii_rx_valid;
    logic mii_collision;
  } pfm_mii_rx_s;

  typedef struct packed {
    logic timer6_alt_clock;
    logic timer7_alt_clock;
    logic timer0_alt_clock;
    logic timer1_alt_clock;
    logic timer0_alt_capture;
    logic timer1_alt_capture;
  } pfm_tmr_s;

  // -----------------------------------------------------------
  // module state
  // -----------------------------------------------------------
  typedef struct packed {
    pfm_mode_e mode;
    logic [3:0] cnt;
    pfm_emi_s emi;
    logic emi_oe;
    logic [15:0] data_out;
    logic data_oe;
    logic data_ie;
    logic [1:0] byte_enable_or_mask;
    logic sync_mem_clock_out;
    logic buffered_crystal_out;
    logic xtal_oe;
    logic force_hiz;
  } pfm_state_s;

  typedef struct packed {
    pfm_fn_e sel;
    logic s1;
    logic s2;
    logic s3;
    logic stable;
    logic pad_out;
    logic pad_oe;
    logic pad_ie;
    logic [5:0] in_vec;
  } pfm_pin_state_s;

endpackage

// file: rtl/pfm_pin_sel.sv
`timescale 1ns/1ns
`default_nettype none
`include "pfm_map.svh"

module pfm_pin_sel #(
  parameter logic [5:0] AVAIL = 6'h01
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // control
  input wire logic force_hiz,
  input wire logic [2:0] fn_sel,
  // per-function drive, enable and input request
  input wire logic [5:0] out_vec,
  input wire logic [5:0] oe_vec,
  input wire logic [5:0] ie_vec,
  // pad
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pad_ie,
  // per-function input value, inactive when not selected
  output logic [5:0] in_vec
);
  import pfm_pkg::*;

  pfm_pin_state_s st;
  pfm_pin_state_s next_st;
  logic [2:0] idx;

  always_comb
  begin
    next_st = st;
    next_st.s1 = pad_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3)
    begin
      next_st.stable = st.s3;
    end
    // default function while forced, only offered functions otherwise
    if (force_hiz)
    begin
      next_st.sel = PFM_FN_GPIO;
    end
    else if (fn_sel < 3'(`PFM_FN_COUNT) && AVAIL[fn_sel])
    begin
      next_st.sel = pfm_fn_e'(fn_sel);
    end
    idx = st.sel;
    // single driver per pad, inputs of other functions held low
    next_st.pad_oe = !force_hiz && oe_vec[idx];
    next_st.pad_out = out_vec[idx];
    next_st.pad_ie = !force_hiz && ie_vec[idx];
    next_st.in_vec = 6'h00;
    if (next_st.pad_ie)
    begin
      next_st.in_vec[idx] = st.stable;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pad_out = st.pad_out;
  assign pad_oe = st.pad_oe;
  assign pad_ie = st.pad_ie;
  assign in_vec = st.in_vec;

endmodule
`default_nettype wire

// file: verification/pfm_pad_ctrl_sva.sv
`timescale 1ns/1ns
`default_nettype none
module pfm_pad_ctrl_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // watched ports
  input wire logic hibernate_req,
  input wire pfm_pkg::pfm_emi_s emi_in,
  input wire pfm_pkg::pfm_emi_s emi_out,
  input wire logic emi_oe,
  input wire logic data_oe,
  input wire logic [1:0] async_byte_enable,
  input wire logic [1:0] sync_data_mask,
  input wire logic mem_access_sync,
  input wire logic [1:0] byte_enable_or_mask,
  input wire logic sync_mem_clock_out,
  input wire logic buffered_crystal_oe,
  input wire logic [23:0] pf_fn_sel,
  input wire logic [7:0] parallel_port_out,
  input wire logic parallel_port_oe,
  input wire logic [7:0] portf_pin_out,
  input wire logic [7:0] portf_pin_oe,
  input wire logic [7:0] portf_pin_ie
);
  import pfm_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  logic [3:0] run_cnt = 4'h0;
  logic [1:0] age = 2'h0;
  logic run;
  // cycles since start (age) and since reset release (run_cnt), saturating
  always_ff @(posedge mclk)
  begin
    age <= (age == 2'h3) ? age : age + 2'h1;
    run_cnt <= reset ? 4'h0 : ((run_cnt == 4'hf) ? run_cnt : run_cnt + 4'h1);
  end
  assign run = (run_cnt == 4'hf);
  sequence s_held;
    emi_oe && portf_pin_oe == 8'h00 && byte_enable_or_mask == 2'h3;
  endsequence
  a_reset_emi_high: assert property (reset |=> (emi_out == '1) and s_held)
    else $error("memory outputs not high in reset");
  a_reset_pf_hiz: assert property (reset |=> portf_pin_ie == 8'h00 && !data_oe)
    else $error("port pins not floating in reset");
  a_clock_toggles: assert property (
    age == 2'h3 |=> sync_mem_clock_out != $past(sync_mem_clock_out))
    else $error("memory clock stopped");
  a_post_hold: assert property (disable iff (reset) $fell(reset) |-> s_held [*6])
    else $error("reset state not held after release");
  a_emi_follow: assert property (disable iff (reset)
    run && !$past(hibernate_req) |-> emi_out == $past(emi_in))
    else $error("memory outputs do not follow controller");
  a_mask_select: assert property (disable iff (reset)
    run && !$past(hibernate_req) |-> byte_enable_or_mask == ($past(mem_access_sync) ?
    $past(sync_data_mask) : $past(async_byte_enable)))
    else $error("byte enable or mask wrong");
  a_hiber_float: assert property (disable iff (reset)
    run && hibernate_req |=> (!emi_oe && !data_oe && !buffered_crystal_oe)
    ##1 portf_pin_oe == 8'h00)
    else $error("outputs driven in hibernate");
  a_pin0_ppi: assert property (disable iff (reset)
    run && $past(pf_fn_sel[2:0], 2) == 3'h2 && $past(pf_fn_sel[2:0]) == 3'h2
    && $past(parallel_port_oe) && !$past(hibernate_req) && !$past(hibernate_req, 2)
    && !$past(hibernate_req, 3) |-> portf_pin_oe[0]
    && portf_pin_out[0] == $past(parallel_port_out[0]))
    else $error("pin 0 parallel data wrong");
endmodule
bind pfm_pad_ctrl pfm_pad_ctrl_sva pfm_pad_ctrl_sva_inst (.mclk, .reset, .hibernate_req, .emi_in,
  .emi_out, .emi_oe, .data_oe, .async_byte_enable, .sync_data_mask, .mem_access_sync,
  .byte_enable_or_mask, .sync_mem_clock_out, .buffered_crystal_oe, .pf_fn_sel,
  .parallel_port_out, .parallel_port_oe, .portf_pin_out, .portf_pin_oe, .portf_pin_ie);
`default_nettype wire

// file: verification/pfm_pad_model.sv
`timescale 1ns/1ns
`default_nettype none
module pfm_pad_model (
  // clock
  input wire logic mclk,
  // device side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  // far side drive
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // resolved pads
  output logic [7:0] pad
);
  logic [7:0] last = 8'h00;
  always_ff @(posedge mclk)
  begin
    last <= pad;
  end
  // floating pads show the inverse of the last level
  assign pad = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & ~last);
endmodule
`default_nettype wire

// file: verification/pfm_pad_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pfm_pad_ctrl_tb;
  import pfm_pkg::*;
  logic mclk = 1'b0, reset = 1'b1, hibernate_req = 1'b0, data_oe_in = 1'b0;
  logic mem_access_sync = 1'b0, xtal_in = 1'b0, parallel_port_oe = 1'b0;
  logic mii_tx_bit2 = 1'b0, mii_tx_bit3 = 1'b0, pwm_sync_out = 1'b0;
  logic spi_b_select2 = 1'b0, spi_a_select1 = 1'b0;
  pfm_emi_s emi_in = '0;
  logic [15:0] data_out_in = 16'h0000;
  logic [1:0] async_byte_enable = 2'h0, sync_data_mask = 2'h0;
  logic [23:0] pf_fn_sel = 24'h00_0000;
  logic [7:0] gpio_out = 8'h00, gpio_oe = 8'h00, gpio_ie = 8'h00, parallel_port_out = 8'h00;
  logic [7:0] ext_val = 8'h00, ext_en = 8'h00, pad;
  logic [5:0] pwm_out = 6'h00;
  pfm_emi_s emi_out;
  logic emi_oe, data_oe, data_ie, sync_mem_clock_out, buffered_crystal_out, buffered_crystal_oe;
  logic [15:0] data_out;
  logic [1:0] byte_enable_or_mask;
  logic [7:0] portf_pin_out, portf_pin_oe, portf_pin_ie, gpio_in, parallel_port_in;
  pfm_mii_rx_s mii_rx;
  pfm_tmr_s timer_in;
  int fails = 0, tests_run = 0;
  always #4 mclk = ~mclk;
  always @(posedge mclk) xtal_in <= ~xtal_in;
  pfm_pad_ctrl pfm_pad_ctrl_inst (.mclk, .reset, .hibernate_req, .emi_in, .data_out_in,
    .data_oe_in, .async_byte_enable, .sync_data_mask, .mem_access_sync, .xtal_in, .emi_out,
    .emi_oe, .data_out, .data_oe, .data_ie, .byte_enable_or_mask, .sync_mem_clock_out,
    .buffered_crystal_out, .buffered_crystal_oe, .pf_fn_sel, .gpio_out, .gpio_oe, .gpio_ie,
    .mii_tx_bit2, .mii_tx_bit3, .parallel_port_out, .parallel_port_oe, .pwm_out, .pwm_sync_out,
    .spi_b_select2, .spi_a_select1, .portf_pin_in(pad), .portf_pin_out, .portf_pin_oe,
    .portf_pin_ie, .gpio_in, .parallel_port_in, .mii_rx, .timer_in);
  pfm_pad_model pfm_pad_model_inst (.mclk, .pin_out(portf_pin_out), .pin_oe(portf_pin_oe),
    .ext_val, .ext_en, .pad);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic at(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic set_fn(input logic [2:0] fn);
    @(posedge mclk);
    pf_fn_sel <= {8{fn}};
    at(8);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic t_reset;
    logic c;
    at(5);
    chk(32'(emi_out), 32'h1fff_ffff);
    chk({emi_oe, byte_enable_or_mask, buffered_crystal_oe}, 4'hf);
    chk({portf_pin_oe, portf_pin_ie, data_oe, data_ie}, 18'h0_0000);
    c = sync_mem_clock_out;
    @(posedge mclk);
    reset <= 1'b0;
    #1;
    chk(sync_mem_clock_out, !c);
    at(4);
    chk({emi_oe, portf_pin_oe}, 9'h100);
    at(6);
  endtask
  task automatic t_emi;
    pfm_emi_s v;
    v = ~pfm_emi_s'(0);
    v.addr = 19'h2_1234;
    v.async_read_en_n = 1'b0;
    @(posedge mclk);
    emi_in <= v;
    data_oe_in <= 1'b1;
    data_out_in <= 16'hbeef;
    async_byte_enable <= 2'h1;
    sync_data_mask <= 2'h2;
    at(2);
    chk(32'(emi_out), 32'(v));
    chk({data_oe, data_ie, data_out}, 18'h2_beef);
    chk(byte_enable_or_mask, 2'h1);
    chk(buffered_crystal_out, !xtal_in);
    @(posedge mclk);
    mem_access_sync <= 1'b1;
    at(2);
    chk(byte_enable_or_mask, 2'h2);
  endtask
  task automatic t_gpio;
    @(posedge mclk);
    gpio_out <= 8'ha5;
    gpio_oe <= 8'h0f;
    gpio_ie <= 8'hf0;
    ext_en <= 8'hff;
    ext_val <= 8'h3c;
    at(8);
    chk({portf_pin_oe, portf_pin_out & 8'h0f, portf_pin_ie}, 24'h0f_05f0);
    chk(gpio_in & 8'hf0, 8'h30);
  endtask
  task automatic t_ppi;
    @(posedge mclk);
    parallel_port_oe <= 1'b1;
    parallel_port_out <= 8'h5a;
    set_fn(3'h2);
    chk({portf_pin_oe, portf_pin_out}, 16'hff5a);
    chk(gpio_in, 8'h00);
    @(posedge mclk);
    parallel_port_oe <= 1'b0;
    at(8);
    chk({portf_pin_oe, parallel_port_in}, 16'h003c);
  endtask
  task automatic t_pwm;
    @(posedge mclk);
    pwm_out <= 6'h2d;
    pwm_sync_out <= 1'b1;
    set_fn(3'h3);
    chk({portf_pin_oe & 8'hfe, portf_pin_out & 8'hfe}, 16'hfeda);
  endtask
  task automatic t_mii;
    @(posedge mclk);
    mii_tx_bit2 <= 1'b1;
    mii_tx_bit3 <= 1'b1;
    ext_val <= 8'h52;
    set_fn(3'h1);
    chk({portf_pin_oe & 8'h7f, portf_pin_out & 8'h05}, 16'h0505);
    chk(mii_rx, 5'h15);
    chk(timer_in, 6'h00);
  endtask
  task automatic t_spi;
    @(posedge mclk);
    spi_b_select2 <= 1'b1;
    spi_a_select1 <= 1'b1;
    set_fn(3'h4);
    chk({portf_pin_oe & 8'h81, portf_pin_out & 8'h81}, 16'h8181);
  endtask
  task automatic t_tmr;
    set_fn(3'h5);
    chk(portf_pin_oe & 8'h7b, 8'h00);
    chk(timer_in, 6'h15);
    set_fn(3'h7);
    chk({portf_pin_oe & 8'h7b, 2'h0, timer_in}, 16'h0015);
  endtask
  task automatic t_hiber;
    @(posedge mclk);
    hibernate_req <= 1'b1;
    at(2);
    chk({emi_oe, data_oe, buffered_crystal_oe, portf_pin_oe}, 11'h000);
    @(posedge mclk);
    hibernate_req <= 1'b0;
    at(3);
    chk({emi_oe, buffered_crystal_oe}, 2'h3);
  endtask
  initial
  begin
    t_reset;
    t_emi;
    t_gpio;
    t_ppi;
    t_pwm;
    t_mii;
    t_spi;
    t_tmr;
    t_hiber;
    wrap_up;
  end
  // hang guard
  initial
  begin
    repeat (2000) @(posedge mclk);
    fails++;
    wrap_up;
  end
endmodule
`default_nettype wire
